// ===== logic/ulpi_link_pkg.sv
// Purpose: Shared constants and types for the transceiver link logic.
// Assumes: System clock of 50 MHz; the link clock is sampled, not used as a clock.
// Notes: Speed codes are local encodings for the speed select ports.
`default_nettype none
package ulpi_link_pkg;
    localparam int DATA_W = 8;
    localparam int FIFO_DEPTH = 32;
    localparam int SYNC_W = 11;
    localparam logic [7:0] IDLE_BYTE = 8'h00;
    localparam logic [1:0] SPD_HS = 2'h0;
    localparam logic [1:0] SPD_FS = 2'h1;
    localparam logic [1:0] SPD_LS = 2'h2;
    // Bit positions inside the synchroniser word.
    localparam int SB_CLK = 10;
    localparam int SB_DIR = 9;
    localparam int SB_NXT = 8;

    typedef enum logic [4:0] {
        ST_IDLE = 5'b00001,
        ST_TX = 5'b00010,
        ST_STOP = 5'b00100,
        ST_RX = 5'b01000,
        ST_TURN = 5'b10000
    } link_state_e;

    typedef struct packed {
        logic last;
        logic [DATA_W-1:0] data;
    } tx_word_s;

    typedef struct packed {
        logic [SYNC_W-1:0] s1;
        logic [SYNC_W-1:0] s2;
        logic [SYNC_W-1:0] s3;
        logic clk_lvl;
        link_state_e st;
        logic [DATA_W-1:0] data;
        logic oe_n;
        logic stp;
        logic cur_last;
        logic hold_v;
        tx_word_s hold;
        logic req_pend;
        logic [DATA_W-1:0] rx_data;
        logic rx_valid;
        logic rx_active;
        logic bidir;
        logic [1:0] speed;
    } link_state_s;
endpackage
`default_nettype wire

// ===== logic/ulpi_link.sv
// Purpose: Link-side controller logic of the 8-bit SDR transceiver interface.
// Assumes: All transceiver pins (clock, direction, next, data) arrive asynchronously and pass a three-stage synchroniser.
// Notes: A 32-word transmit FIFO decouples the user stream from the link.
`default_nettype none

module tx_fifo #(
    parameter int WIDTH = 9,
    parameter int DEPTH = 32
) (
    input wire logic clk_sys_i,
    input wire logic srst_i,
    input wire logic in_valid_i,
    input wire logic [WIDTH-1:0] in_data_i,
    output logic in_ready_o,
    output logic out_valid_o,
    output logic [WIDTH-1:0] out_data_o,
    input wire logic out_ready_i
);
    localparam int AW = $clog2(DEPTH);
    typedef struct packed {
        logic [AW-1:0] wr;
        logic [AW-1:0] rd;
        logic [AW:0] cnt;
        logic rdy;
    } fifo_state_s;
    fifo_state_s r_reg, r_next;
    logic [WIDTH-1:0] mem [DEPTH];
    logic push, pop;

    assign push = in_valid_i && r_reg.rdy;
    assign pop = out_ready_i && (r_reg.cnt != '0);
    assign in_ready_o = r_reg.rdy;
    assign out_valid_o = (r_reg.cnt != '0);
    assign out_data_o = mem[r_reg.rd];

    always_comb begin
        r_next = r_reg;
        if (push) begin
            r_next.wr = r_reg.wr + 1'b1;
        end
        if (pop) begin
            r_next.rd = r_reg.rd + 1'b1;
        end
        r_next.cnt = r_reg.cnt + (AW+1)'(push) - (AW+1)'(pop);
        // Ready is registered so the user port sees a flop; this costs one free slot.
        r_next.rdy = (r_next.cnt < (AW+1)'(DEPTH - 1));
    end

    always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
            r_reg <= '0;
        end else begin
            r_reg <= r_next;
        end
        if (push) begin
            mem[r_reg.wr] <= in_data_i;
        end
    end
endmodule

module ulpi_link #(
    parameter int FIFO_DEPTH = ulpi_link_pkg::FIFO_DEPTH
) (
    input wire logic clk_sys_i,
    input wire logic srst_i,
    input wire logic link_clk_i,
    input wire logic bus_dir_i,
    input wire logic next_byte_i,
    input wire logic [7:0] link_data_i,
    output logic [7:0] link_data_o,
    output logic link_data_oe_n_o,
    output logic stop_o,
    input wire logic bidir_i,
    input wire logic role_host_i,
    input wire logic [1:0] speed_req_i,
    output logic [1:0] speed_o,
    input wire logic tx_valid_i,
    input wire logic [7:0] tx_data_i,
    input wire logic tx_last_i,
    output logic tx_ready_o,
    input wire logic rd_req_i,
    output logic [7:0] rx_data_o,
    output logic rx_valid_o,
    output logic rx_active_o
);
    ulpi_link_pkg::link_state_s r, n;
    ulpi_link_pkg::tx_word_s f_in, f_out;
    logic f_valid, f_ready;
    logic evt, dir_q, nxt_q, release_next;
    logic [7:0] din_q;

    assign f_in.last = tx_last_i;
    assign f_in.data = tx_data_i;

    tx_fifo #(
        .WIDTH($bits(ulpi_link_pkg::tx_word_s)),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .clk_sys_i(clk_sys_i),
        .srst_i(srst_i),
        .in_valid_i(tx_valid_i),
        .in_data_i(f_in),
        .in_ready_o(tx_ready_o),
        .out_valid_o(f_valid),
        .out_data_o(f_out),
        .out_ready_i(f_ready)
    );

    // A link clock edge counts only once stages two and three agree.
    assign evt = r.s2[ulpi_link_pkg::SB_CLK] && r.s3[ulpi_link_pkg::SB_CLK] && !r.clk_lvl;
    assign dir_q = r.s3[ulpi_link_pkg::SB_DIR];
    assign nxt_q = r.s3[ulpi_link_pkg::SB_NXT];
    assign din_q = r.s3[7:0];
    assign f_ready = !r.hold_v;

    always_comb begin
        n = r;
        n.s1 = {link_clk_i, bus_dir_i, next_byte_i, link_data_i};
        n.s2 = r.s1;
        n.s3 = r.s2;
        if (r.s2[ulpi_link_pkg::SB_CLK] == r.s3[ulpi_link_pkg::SB_CLK]) begin
            n.clk_lvl = r.s3[ulpi_link_pkg::SB_CLK];
        end
        n.rx_valid = 1'b0;
        n.bidir = bidir_i;
        // Prefetch one byte so the next one is ready at the accepting edge.
        if (!r.hold_v && f_valid) begin
            n.hold_v = 1'b1;
            n.hold = f_out;
        end
        if (rd_req_i) begin
            n.req_pend = 1'b1;
        end
        if (evt) begin
            n.stp = 1'b0;
            if (dir_q) begin
                // Bus released when bidirectional; a running transmit is aborted by the transceiver.
                n.st = ulpi_link_pkg::ST_RX;
                n.data = ulpi_link_pkg::IDLE_BYTE;
                n.rx_active = 1'b1;
                if (nxt_q && r.st == ulpi_link_pkg::ST_RX) begin
                    n.rx_data = din_q;
                    n.rx_valid = 1'b1;
                end
            end else begin
                n.rx_active = 1'b0;
                case (r.st)
                    ulpi_link_pkg::ST_IDLE: begin
                        n.data = ulpi_link_pkg::IDLE_BYTE;
                        if (r.hold_v) begin
                            n.st = ulpi_link_pkg::ST_TX;
                            n.data = r.hold.data;
                            n.cur_last = r.hold.last;
                            n.hold_v = 1'b0;
                        end else if (r.req_pend) begin
                            n.stp = 1'b1;
                            n.req_pend = rd_req_i;
                            n.st = ulpi_link_pkg::ST_STOP;
                        end
                    end
                    ulpi_link_pkg::ST_TX: begin
                        if (nxt_q) begin
                            if (r.cur_last) begin
                                n.stp = 1'b1;
                                n.data = ulpi_link_pkg::IDLE_BYTE;
                                n.st = ulpi_link_pkg::ST_STOP;
                            end else if (r.hold_v) begin
                                n.data = r.hold.data;
                                n.cur_last = r.hold.last;
                                n.hold_v = 1'b0;
                            end
                            // On underrun the byte stays presented until refilled.
                        end
                    end
                    ulpi_link_pkg::ST_STOP: begin
                        n.st = ulpi_link_pkg::ST_IDLE;
                        n.data = ulpi_link_pkg::IDLE_BYTE;
                    end
                    ulpi_link_pkg::ST_RX: begin
                        n.st = ulpi_link_pkg::ST_TURN;
                    end
                    ulpi_link_pkg::ST_TURN: begin
                        n.st = ulpi_link_pkg::ST_IDLE;
                        n.data = ulpi_link_pkg::IDLE_BYTE;
                    end
                    default: begin
                        n.st = ulpi_link_pkg::ST_IDLE;
                        n.data = ulpi_link_pkg::IDLE_BYTE;
                    end
                endcase
            end
        end
        // A unidirectional bus has separate lines, so no release is needed.
        release_next = (n.st == ulpi_link_pkg::ST_RX) || (n.st == ulpi_link_pkg::ST_TURN);
        n.oe_n = bidir_i && release_next;
        if (!role_host_i && speed_req_i == ulpi_link_pkg::SPD_LS) begin
            n.speed = ulpi_link_pkg::SPD_FS;
        end else begin
            n.speed = speed_req_i;
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
            r <= '0;
            r.st <= ulpi_link_pkg::ST_IDLE;
            r.oe_n <= 1'b1;
        end else begin
            r <= n;
        end
    end

    assign link_data_o = r.data;
    assign link_data_oe_n_o = r.oe_n;
    assign stop_o = r.stp;
    assign speed_o = r.speed;
    assign rx_data_o = r.rx_data;
    assign rx_valid_o = r.rx_valid;
    assign rx_active_o = r.rx_active;

    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (srst_i);

    sequence s_last_taken;
        r.st == ulpi_link_pkg::ST_TX && evt && !dir_q && nxt_q && r.cur_last;
    endsequence
    sequence s_stop_pulse;
        stop_o && link_data_o == 8'h00 ##1 stop_o [*1];
    endsequence

    property p_launch_on_edge;
        $changed(stop_o) |-> $past(evt);
    endproperty
    a_launch_on_edge: assert property (p_launch_on_edge)
        else $error("stop changed away from a link edge");

    property p_end_stop;
        s_last_taken |=> s_stop_pulse;
    endproperty
    a_end_stop: assert property (p_end_stop)
        else $error("no stop after the last byte");

    property p_req_stop;
        r.st == ulpi_link_pkg::ST_IDLE && evt && !dir_q && !r.hold_v && r.req_pend
            |=> stop_o && r.st == ulpi_link_pkg::ST_STOP;
    endproperty
    a_req_stop: assert property (p_req_stop)
        else $error("read request did not raise stop");

    // Reset leaves the bus released, so the first cycle after reset is exempt.
    property p_idle_zero;
        r.st == ulpi_link_pkg::ST_IDLE && !$past(srst_i)
            |-> link_data_o == 8'h00 && !link_data_oe_n_o;
    endproperty
    a_idle_zero: assert property (p_idle_zero)
        else $error("idle bus not driven to zero");

    property p_uni_drive;
        !bidir_i |=> !link_data_oe_n_o;
    endproperty
    a_uni_drive: assert property (p_uni_drive)
        else $error("unidirectional bus released");

    property p_no_ls_device;
        !role_host_i |=> speed_o != ulpi_link_pkg::SPD_LS;
    endproperty
    a_no_ls_device: assert property (p_no_ls_device)
        else $error("low speed offered as peripheral");

    property p_turnaround;
        r.st == ulpi_link_pkg::ST_RX && evt && !dir_q && bidir_i
            |=> link_data_oe_n_o && r.st == ulpi_link_pkg::ST_TURN;
    endproperty
    a_turnaround: assert property (p_turnaround)
        else $error("bus driven without turnaround");
endmodule
`default_nettype wire

// ===== testbench/ulpi_phy_model.sv
// Purpose: Behavioural transceiver on the far side of the link.
// Assumes: Outputs launch on link clock falling edges, half a period before sampling.
// Notes: The link clock runs free, since the transceiver supplies it at all times.
`default_nettype none
module ulpi_phy_model (
    input wire logic stall_i,
    input wire logic [7:0] ctrl_data_i,
    input wire logic stop_i,
    output logic link_clk_o,
    output logic dir_o,
    output logic nxt_o,
    output logic [7:0] data_o
);
    timeunit 1ns;
    timeprecision 1ns;
    logic busy;
    initial begin
        {link_clk_o, dir_o, nxt_o, busy} = 4'h0;
        data_o = 8'h00;
        #7;
        forever #80 link_clk_o = ~link_clk_o;
    end
    // A stall holds next-byte low, the way a slow transceiver would.
    always @(negedge link_clk_o) begin
        if (!busy) begin
            nxt_o <= !stall_i && !stop_i && ctrl_data_i != 8'h00;
        end
    end
    task automatic deliver(input logic [7:0] b[$], input int gap);
        busy = 1'b1;
        @(negedge link_clk_o);
        dir_o <= 1'b1;
        nxt_o <= 1'b0;
        foreach (b[i]) begin
            repeat (gap) begin
                @(negedge link_clk_o);
                nxt_o <= 1'b0;
                data_o <= ~b[i];
            end
            @(negedge link_clk_o);
            nxt_o <= 1'b1;
            data_o <= b[i];
        end
        @(negedge link_clk_o);
        {dir_o, nxt_o} <= 2'h0;
        #10 busy = 1'b0;
    endtask
endmodule
`default_nettype wire

// ===== testbench/ulpi_link_tb_top.sv
// Purpose: Self-checking bench for the link controller.
// Assumes: Link clock offset from the system clock so no edges coincide.
// Notes: Sent bytes are kept nonzero so an idle bus never reads as data.
`default_nettype none
module ulpi_link_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk_sys_i, srst_i, bidir_i, role_host_i, tx_valid_i, tx_last_i, rd_req_i, stall;
    logic [1:0] speed_req_i;
    logic [7:0] tx_data_i;
    logic [31:0] rng = 32'h0000_21c3;
    logic [7:0] exp_q[$], got_q[$], rx_q[$], q[$];
    logic dir_q, filled;
    int mismatches, checks, stops, s;
    wire logic lclk, dir, nxt, oe_n, stop_o, tx_ready_o, rx_valid_o, rx_active;
    wire logic [7:0] phy_data, data_o, rx_data_o, link_d;
    wire logic [1:0] speed_o;
    // A released bus shows the inverse of its last level, never a held copy.
    assign link_d = !bidir_i ? phy_data : (!oe_n ? data_o : (dir ? phy_data : ~data_o));
    ulpi_link dut (.clk_sys_i(clk_sys_i), .srst_i(srst_i), .link_clk_i(lclk), .bus_dir_i(dir),
        .next_byte_i(nxt), .link_data_i(link_d), .link_data_o(data_o),
        .link_data_oe_n_o(oe_n), .stop_o(stop_o), .bidir_i(bidir_i),
        .role_host_i(role_host_i), .speed_req_i(speed_req_i), .speed_o(speed_o),
        .tx_valid_i(tx_valid_i), .tx_data_i(tx_data_i), .tx_last_i(tx_last_i),
        .tx_ready_o(tx_ready_o), .rd_req_i(rd_req_i), .rx_data_o(rx_data_o),
        .rx_valid_o(rx_valid_o), .rx_active_o(rx_active));
    ulpi_phy_model phy (.stall_i(stall), .ctrl_data_i((oe_n && bidir_i) ? 8'h00 : data_o),
        .stop_i(stop_o), .link_clk_o(lclk), .dir_o(dir), .nxt_o(nxt), .data_o(phy_data));
    initial begin
        clk_sys_i = 1'b0;
        forever #10 clk_sys_i = ~clk_sys_i;
    end
    task automatic chk(input logic [7:0] seen, input logic [7:0] want);
        checks++;
        if (seen !== want) begin
            mismatches++;
            $display("unexpected at %0t: saw %h want %h", $time, seen, want);
        end
    endtask
    task automatic end_sim();
        $display("mismatches %0d checks %0d", mismatches, checks);
        if (mismatches == 0 && checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic timeout();
        mismatches++;
        $display("unexpected at %0t: wait ran out", $time);
        end_sim();
    endtask
    function automatic logic [7:0] rnd_byte();
        rng = rng ^ (rng << 13);
        rng = rng ^ (rng >> 17);
        rng = rng ^ (rng << 5);
        return rng[7:0] | 8'h01;
    endfunction
    function automatic logic [1:0] want_speed(input logic host, input logic [1:0] req);
        return (!host && req == ulpi_link_pkg::SPD_LS) ? ulpi_link_pkg::SPD_FS : req;
    endfunction
    always @(posedge lclk) begin
        if (!srst_i) begin
            if (dir_q && bidir_i) chk(oe_n, 1'b1);
            if (!bidir_i) chk(oe_n, 1'b0);
            chk(rx_active, dir_q);
            if (stop_o) begin
                stops++;
                chk(data_o, ulpi_link_pkg::IDLE_BYTE);
            end else if (nxt && !dir && data_o != 8'h00) got_q.push_back(data_o);
        end
        dir_q <= dir;
    end
    always @(posedge clk_sys_i) if (rx_valid_o === 1'b1) rx_q.push_back(rx_data_o);
    task automatic send(input int n);
        int k;
        for (int w = 0; w < n; w++) begin
            tx_data_i <= rnd_byte();
            tx_last_i <= (w == n - 1);
            tx_valid_i <= 1'b1;
            for (k = 0; k < 3000; k++) begin
                @(posedge clk_sys_i);
                if (tx_ready_o === 1'b1) break;
                filled = 1'b1;
            end
            if (k == 3000) timeout();
            exp_q.push_back(tx_data_i);
        end
        tx_valid_i <= 1'b0;
        @(posedge clk_sys_i);
    endtask
    task automatic drain(input int streams);
        int i;
        for (i = 0; i < 20000 && got_q.size() != exp_q.size(); i++) @(posedge clk_sys_i);
        if (i == 20000) timeout();
        repeat (40) @(posedge clk_sys_i);
        while (exp_q.size() > 0) chk(got_q.pop_front(), exp_q.pop_front());
        chk(8'(stops - s), 8'(streams));
        chk(data_o, ulpi_link_pkg::IDLE_BYTE);
        chk(oe_n, 1'b0);
    endtask
    task automatic rx_burst(input int gap);
        q.delete();
        rx_q.delete();
        repeat (6) q.push_back(rnd_byte());
        phy.deliver(q, gap);
        repeat (40) @(posedge clk_sys_i);
        chk(8'(rx_q.size()), 8'd6);
        foreach (q[i]) chk(rx_q[i], q[i]);
    endtask
    initial begin
        {tx_valid_i, tx_last_i, rd_req_i, stall, role_host_i, filled, dir_q} = 7'h00;
        {srst_i, bidir_i, speed_req_i, tx_data_i} = {2'b11, 10'h000};
        {mismatches, checks, stops} = 0;
        repeat (6) @(posedge clk_sys_i);
        srst_i <= 1'b0;
        repeat (4) @(posedge clk_sys_i);
        s = stops;
        send(1);
        send(5);
        send(12);
        drain(3);
        $display("test streams done");
        s = stops;
        stall <= 1'b1;
        fork
            send(40);
            begin
                repeat (2000) @(posedge clk_sys_i);
                chk(filled, 1'b1);
                stall <= 1'b0;
            end
        join
        drain(1);
        $display("test fill done");
        rx_burst(0);
        rx_burst(2);
        bidir_i <= 1'b0;
        rx_burst(1);
        bidir_i <= 1'b1;
        $display("test receive done");
        s = stops;
        rd_req_i <= 1'b1;
        @(posedge clk_sys_i);
        rd_req_i <= 1'b0;
        repeat (60) @(posedge clk_sys_i);
        chk(8'(stops - s), 8'd1);
        $display("test request done");
        for (int r = 0; r < 2; r++) begin
            for (int v = 0; v < 3; v++) begin
                role_host_i <= r[0];
                speed_req_i <= v[1:0];
                repeat (3) @(posedge clk_sys_i);
                chk(speed_o, want_speed(r[0], v[1:0]));
            end
        end
        $display("test speed done");
        end_sim();
    end
endmodule
`default_nettype wire
